// ===== include/bcs_pkg.sv
// Burst cycle sequencer package: request and bus carriers, modes, states,
// byte-enable patterns and line geometry.
// Assumes a 16-bit data bus with 32-bit addresses and active-low strobes.
package bcs_pkg;

   // ------------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------------
   localparam int          LINE_BYTES   = 16;
   localparam int          QWORD_BYTES  = 8;
   localparam int          DWORDS       = 4;
   localparam logic [1:0]  LAST_DWORD   = 2'h3;

   // ------------------------------------------------------------------
   // Byte-enable patterns, active low, bits 3 to 0
   // ------------------------------------------------------------------
   localparam logic [3:0]  BE_NONE      = 4'hf;
   localparam logic [3:0]  BE_ALL       = 4'h0;
   localparam logic [3:0]  BE_UPPER     = 4'h3;
   localparam logic [3:0]  BE_B1_3_1ST  = 4'h1;
   localparam logic [3:0]  BE_B1_2_1ST  = 4'h9;
   localparam logic [3:0]  BE_B1_2_2ND  = 4'hb;
   localparam logic [3:0]  BE_B2_1ST    = 4'h8;
   localparam logic [3:0]  BE_B2_2ND    = 4'hb;

   // Needed-byte masks within one dword that start a two-cycle burst
   localparam logic [3:0]  NEED_B0_4    = 4'hf;
   localparam logic [3:0]  NEED_B1_3    = 4'he;
   localparam logic [3:0]  NEED_B1_2    = 4'h6;
   localparam logic [3:0]  NEED_B2      = 4'h7;

   typedef enum logic [1:0] {
      BCS_MODE_LINE,
      BCS_MODE_QWORD,
      BCS_MODE_DWORD
   } bcs_mode_t;

   typedef enum logic [1:0] {
      BCS_IDLE,
      BCS_ADDR,
      BCS_DATA
   } bcs_state_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [4:0]  len;
      logic        is_mem;
      logic        is_code;
      logic        is_write;
      logic        no_cache;
      logic        locked;
   } bcs_req_t;

   typedef struct packed {
      logic [31:2] addr;
      logic [3:0]  byte_enables_n;
      logic        mem_io;
      logic        data_code;
      logic        write_read;
   } bcs_bus_t;

endpackage

// ===== logic/bcs_be_decode.sv
// Byte-enable pair decode for one dword of a non-line transfer.
// Assumes the needed-byte mask is nonzero when the result is used.
`timescale 1ns/10ps
`default_nettype none

module bcs_be_decode (
   input  wire logic [3:0] need,
   output logic            burst,
   output logic [3:0]      be_first,
   output logic [3:0]      be_second
);

   // ------------------------------------------------------------------
   // Pattern table
   // ------------------------------------------------------------------
   always_comb begin
      burst     = 1'b1;
      be_second = bcs_pkg::BE_UPPER;
      unique case (need)
         bcs_pkg::NEED_B0_4: be_first = bcs_pkg::BE_ALL;
         bcs_pkg::NEED_B1_3: be_first = bcs_pkg::BE_B1_3_1ST;
         bcs_pkg::NEED_B1_2: begin
            be_first  = bcs_pkg::BE_B1_2_1ST;
            be_second = bcs_pkg::BE_B1_2_2ND;
         end
         bcs_pkg::NEED_B2: begin
            be_first  = bcs_pkg::BE_B2_1ST;
            be_second = bcs_pkg::BE_B2_2ND;
         end
         default: begin
            // Any other contiguous mask fits one halfword pair of lanes: single cycle
            burst     = 1'b0;
            be_first  = ~need;
            be_second = bcs_pkg::BE_NONE;
         end
      endcase
   end

endmodule

`default_nettype wire

// ===== logic/bcs_sequencer.sv
// Burst cycle sequencer: turns one transfer request into address strobes,
// byte enables and last-cycle marks on a 16-bit burst bus.
// Assumes a request stays inside one aligned 16-byte line (addr[3:0]+len
// at most 16, len 1 to 16) and that the bus answers each data cycle with
// data_ready_n low.
`timescale 1ns/10ps
`default_nettype none

module bcs_sequencer (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire bcs_pkg::bcs_req_t req,
   output logic                   xfer_done,
   input  wire logic              cache_enable_in_n,
   input  wire logic              data_ready_n,
   output logic                   addr_strobe_n,
   output logic                   last_cycle_n,
   output bcs_pkg::bcs_bus_t      bus,
   output logic                   page_cache_disable,
   output logic                   lock_n
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   bcs_pkg::bcs_state_t state;
   bcs_pkg::bcs_mode_t  mode;
   logic [15:0]         need;
   logic [31:4]         line_addr;
   logic [1:0]          first_dw;
   logic [1:0]          step;
   logic                phase;
   logic                mem_io;
   logic                data_code;
   logic                write_read;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   localparam int DWORDS_M1 = bcs_pkg::DWORDS - 1;

   // Next dword in xor order after position k that still has needed bytes
   function automatic logic [2:0] next_dw(input logic [15:0] nd,
                                          input logic [1:0]  d0,
                                          input logic [1:0]  k);
      logic [2:0] res;
      logic [1:0] dw;
      res = 3'h0;
      for (int i = DWORDS_M1; i >= 1; i--) begin
         dw = d0 ^ 2'(i);
         if (2'(i) > k && nd[4*dw +: 4] != 4'h0) begin
            res = {1'b1, 2'(i)};
         end
      end
      return res;
   endfunction

   // Needed-byte mask of a request inside its line
   function automatic logic [15:0] span_of(input logic [3:0] off,
                                           input logic [4:0] len);
      logic [31:0] s;
      s = ((32'h1 << len) - 32'h1) << off;
      return s[15:0];
   endfunction

   // ------------------------------------------------------------------
   // Current cycle decode
   // ------------------------------------------------------------------
   logic [1:0]  cur_dw;
   logic [3:0]  cur_need;
   logic        dec_burst;
   logic [3:0]  dec_be_first;
   logic [3:0]  dec_be_second;
   logic [3:0]  cur_be;
   logic        group_end;
   logic [15:0] next_need;
   logic [2:0]  nxt;
   logic        more;
   logic        req_cacheable;
   logic        req_line;
   logic        req_qword;
   logic [3:0]  req_end;

   assign cur_dw   = first_dw ^ step;
   assign cur_need = need[4*cur_dw +: 4];

   bcs_be_decode u_be (
      .need      (cur_need),
      .burst     (dec_burst),
      .be_first  (dec_be_first),
      .be_second (dec_be_second)
   );

   always_comb begin
      if (mode == bcs_pkg::BCS_MODE_LINE) begin
         // Line order: lower half all lanes, then upper half
         cur_be    = phase ? bcs_pkg::BE_UPPER : bcs_pkg::BE_ALL;
         group_end = phase;
      end else begin
         cur_be    = phase ? dec_be_second : dec_be_first;
         group_end = phase | ~dec_burst;
      end
   end

   // Clear the dword once its group is done, then look for more work
   always_comb begin
      next_need = need;
      if (group_end) begin
         next_need[4*cur_dw +: 4] = 4'h0;
      end
   end

   assign nxt  = next_dw(next_need, first_dw, step);
   assign more = (mode == bcs_pkg::BCS_MODE_LINE) ?
                 (next_need != 16'h0 && step != bcs_pkg::LAST_DWORD) :
                 nxt[2];

   // ------------------------------------------------------------------
   // Request classification
   // ------------------------------------------------------------------
   assign req_end = 4'(req.addr[3:0] + 4'(req.len - 5'h1));
   assign req_cacheable = req.is_mem && !req.is_write && !req.no_cache &&
                          !req.locked && !cache_enable_in_n;
   // Code prefetch, cacheable fills and memory reads past a quadword use line order
   assign req_line  = req_cacheable || req.is_code ||
                      (req.addr[3] != req_end[3]);
   assign req_qword = req.is_mem && !req.is_write && !req_line;

   // ------------------------------------------------------------------
   // Sequencing
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= bcs_pkg::BCS_IDLE;
      end else begin
         unique case (state)
            bcs_pkg::BCS_IDLE: begin
               if (req_valid) begin
                  state <= bcs_pkg::BCS_ADDR;
               end
            end
            bcs_pkg::BCS_ADDR: state <= bcs_pkg::BCS_DATA;
            bcs_pkg::BCS_DATA: begin
               if (!data_ready_n && group_end) begin
                  if (!more) begin
                     state <= bcs_pkg::BCS_IDLE;
                  end else if (mode == bcs_pkg::BCS_MODE_DWORD) begin
                     // Each dword group is its own bus cycle
                     state <= bcs_pkg::BCS_ADDR;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         mode  <= bcs_pkg::BCS_MODE_DWORD;
         need  <= 16'h0;
         step  <= 2'h0;
         phase <= 1'b0;
      end else if (state == bcs_pkg::BCS_IDLE && req_valid) begin
         step  <= 2'h0;
         phase <= 1'b0;
         if (req_line && !req.is_write && req.is_mem) begin
            mode <= bcs_pkg::BCS_MODE_LINE;
            // Fills and prefetches take all sixteen bytes
            need <= (req_cacheable || req.is_code) ? 16'hffff :
                    span_of(req.addr[3:0], req.len);
         end else begin
            mode <= req_qword ? bcs_pkg::BCS_MODE_QWORD :
                                bcs_pkg::BCS_MODE_DWORD;
            need <= span_of(req.addr[3:0], req.len);
         end
      end else if (state == bcs_pkg::BCS_DATA && !data_ready_n) begin
         need <= next_need;
         if (!group_end) begin
            phase <= 1'b1;
         end else begin
            phase <= 1'b0;
            if (mode == bcs_pkg::BCS_MODE_LINE) begin
               step <= 2'(step + 2'h1);
            end else begin
               // Quadword reads only ever find the partner dword
               step <= nxt[1:0];
            end
         end
      end
   end

   // Controls and upper address are latched once per request
   always_ff @(posedge clk) begin
      if (!nrst) begin
         line_addr          <= 28'h0;
         first_dw           <= 2'h0;
         mem_io             <= 1'b0;
         data_code          <= 1'b0;
         write_read         <= 1'b0;
         page_cache_disable <= 1'b0;
         lock_n             <= 1'b1;
      end else if (state == bcs_pkg::BCS_IDLE && req_valid) begin
         line_addr          <= req.addr[31:4];
         first_dw           <= req.addr[3:2];
         mem_io             <= req.is_mem;
         data_code          <= ~req.is_code;
         write_read         <= req.is_write;
         page_cache_disable <= req.no_cache;
         lock_n             <= ~req.locked;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         xfer_done <= 1'b0;
      end else begin
         xfer_done <= (state == bcs_pkg::BCS_DATA) && !data_ready_n &&
                      group_end && !more;
      end
   end

   // ------------------------------------------------------------------
   // Bus outputs
   // ------------------------------------------------------------------
   // Address bits 31..2 change only between dword groups, never in one
   // two-cycle burst, since step moves only at a group end.
   always_comb begin
      bus = '0;
      bus.byte_enables_n = bcs_pkg::BE_NONE;
      if (state != bcs_pkg::BCS_IDLE) begin
         bus.addr           = {line_addr, cur_dw};
         bus.byte_enables_n = cur_be;
         bus.mem_io         = mem_io;
         bus.data_code      = data_code;
         bus.write_read     = write_read;
      end
   end

   assign req_ready     = (state == bcs_pkg::BCS_IDLE);
   assign addr_strobe_n = (state != bcs_pkg::BCS_ADDR);
   // Line and quadword reads stay one burst; dword groups end on their own
   assign last_cycle_n  = !((state == bcs_pkg::BCS_DATA) && group_end &&
                            (!more ||
                             mode == bcs_pkg::BCS_MODE_DWORD));

endmodule

`default_nettype wire

// ===== verif/bcs_sequencer_asserts.sv
// Port assertions for the burst cycle sequencer.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module bcs_seq_chk (
   input wire logic              clk,
   input wire logic              nrst,
   input wire logic              req_valid,
   input wire logic              req_ready,
   input wire logic              xfer_done,
   input wire logic              data_ready_n,
   input wire logic              addr_strobe_n,
   input wire logic              last_cycle_n,
   input wire bcs_pkg::bcs_bus_t bus,
   input wire logic              page_cache_disable,
   input wire logic              lock_n
);
   // ----------------------------
   // Beats since address strobe
   // ----------------------------
   logic       ack;
   logic       wio;
   logic [3:0] beats;
   assign ack = addr_strobe_n && !req_ready && !data_ready_n;
   assign wio = bus.write_read || !bus.mem_io;
   always_ff @(posedge clk) begin
      if (!nrst || !addr_strobe_n) begin
         beats <= 4'h0;
      end else if (ack) begin
         beats <= beats + 4'h1;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_accept_strobe: assert property (
      req_valid && req_ready |=> !addr_strobe_n) else $error("no strobe");
   chk_wr_pair: assert property (
      ack && last_cycle_n && wio |=> !last_cycle_n && bus.byte_enables_n ==
      ($past(bus.byte_enables_n) inside {4'h0, 4'h1} ? 4'h3 : 4'hb))
      else $error("bad second beat");
   chk_wr_const: assert property (
      ack && last_cycle_n && wio |=> $stable({bus.addr, bus.mem_io,
      bus.data_code, bus.write_read})) else $error("burst controls moved");
   chk_line_end: assert property (
      ack && beats == 4'h7 |-> !last_cycle_n) else $error("no last mark");
   chk_burst_cap: assert property (
      ack |-> beats < 4'h8) else $error("burst too long");
   chk_last_ends: assert property (
      ack && !last_cycle_n |=> !addr_strobe_n || req_ready)
      else $error("burst ran past last mark");
   chk_done_cause: assert property (
      xfer_done |-> $past(ack) && !$past(last_cycle_n) ##1 !xfer_done)
      else $error("bad done pulse");
   chk_cache_hold: assert property (
      !(req_valid && req_ready) |=> $stable(page_cache_disable) &&
      $stable(lock_n)) else $error("cache controls moved");
   cov_line: cover property (ack && beats == 4'h7);
   cov_pair: cover property (ack && wio && !last_cycle_n);
   cov_lock: cover property (xfer_done && !lock_n);
endmodule
bind bcs_sequencer bcs_seq_chk u_chk (
   .clk(clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
   .xfer_done(xfer_done), .data_ready_n(data_ready_n),
   .addr_strobe_n(addr_strobe_n), .last_cycle_n(last_cycle_n), .bus(bus),
   .page_cache_disable(page_cache_disable), .lock_n(lock_n));
`default_nettype wire

// ===== verif/bcs_mem_ctrl.sv
// Memory controller model: acks data cycles and derives lane strobes.
// Assumes the sequencer bus; slow high acks every other cycle.
`timescale 1ns/10ps
`default_nettype none
module bcs_mem_ctrl (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              slow,
   input  wire logic              addr_strobe_n,
   input  wire logic              last_cycle_n,
   input  wire bcs_pkg::bcs_bus_t bus,
   output logic                   data_ready_n,
   output logic                   high_lane_strobe_n,
   output logic                   low_lane_strobe_n,
   output logic                   predicted_addr_bit1,
   output logic                   predicted_addr_bit2,
   output logic                   predicted_addr_bit3
);
   logic in_data;
   logic tog;
   logic next_data;
   logic       saved_initial_bit3;
   logic       saved_initial_bit2;
   logic [1:0] pair;
   // Acked last beat closes the burst
   assign next_data = !addr_strobe_n ||
                      (in_data && (data_ready_n || last_cycle_n));
   always_ff @(posedge clk) begin
      if (!nrst) begin
         in_data <= 1'b0;
         tog <= 1'b0;
         data_ready_n <= 1'b1;
      end else begin
         in_data <= next_data;
         tog <= ~tog;
         data_ready_n <= !(next_data && (!slow || tog));
      end
   end
   always_ff @(posedge clk) begin
      if (!addr_strobe_n) begin
         predicted_addr_bit1 <= bus.byte_enables_n[1:0] == 2'h3;
      end else if (in_data && !data_ready_n) begin
         predicted_addr_bit1 <= ~predicted_addr_bit1;
      end
   end
   // Upper address bits come from the held bus; only the pair index steps
   always_ff @(posedge clk) begin
      if (!addr_strobe_n) begin
         saved_initial_bit3 <= bus.addr[3];
         saved_initial_bit2 <= bus.addr[2];
         pair <= 2'h0;
      end else if (in_data && !data_ready_n && predicted_addr_bit1) begin
         pair <= pair + 2'h1;
      end
   end
   assign predicted_addr_bit3 = saved_initial_bit3 ^ pair[1];
   assign predicted_addr_bit2 = saved_initial_bit2 ^ pair[0];
   assign low_lane_strobe_n = !in_data;
   // High lane known only in the last beat, from its byte enables
   assign high_lane_strobe_n = !in_data ? 1'b1 : last_cycle_n ? 1'b0 :
      (predicted_addr_bit1 ? bus.byte_enables_n[3]
                           : bus.byte_enables_n[1]);
endmodule
`default_nettype wire

// ===== verif/burst_cycle_sequencer_bench.sv
// Self-checking bench for the burst cycle sequencer.
// Assumes bcs_mem_ctrl answers the bus side.
`timescale 1ns/10ps
`default_nettype none
module burst_cycle_sequencer_bench;
   logic              clk = 1'b0;
   logic              nrst = 1'b0;
   logic              req_valid = 1'b0;
   logic              req_ready;
   bcs_pkg::bcs_req_t req = '0;
   logic              xfer_done;
   logic              cache_enable_in_n = 1'b1;
   logic              data_ready_n;
   logic              addr_strobe_n;
   logic              last_cycle_n;
   bcs_pkg::bcs_bus_t bus;
   logic              page_cache_disable;
   logic              lock_n;
   logic              slow = 1'b0;
   logic              predicted_addr_bit2;
   logic              predicted_addr_bit3;
   int                miscompares = 0;
   int                total_checks = 0;
   int                strobe_cnt = 0;
   logic [31:2]       a_q[$];
   logic [3:0]        be_q[$];
   logic              l_q[$];
   logic [1:0]        p_q[$];
   logic [2:0]        c_q[$];
   always #20 clk = ~clk;
   bcs_sequencer u_dut (.clk(clk), .nrst(nrst), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .xfer_done(xfer_done),
      .cache_enable_in_n(cache_enable_in_n), .data_ready_n(data_ready_n),
      .addr_strobe_n(addr_strobe_n), .last_cycle_n(last_cycle_n),
      .bus(bus), .page_cache_disable(page_cache_disable), .lock_n(lock_n));
   bcs_mem_ctrl u_mem (.clk(clk), .nrst(nrst), .slow(slow),
      .addr_strobe_n(addr_strobe_n), .last_cycle_n(last_cycle_n),
      .bus(bus), .data_ready_n(data_ready_n), .high_lane_strobe_n(),
      .low_lane_strobe_n(), .predicted_addr_bit1(),
      .predicted_addr_bit2(predicted_addr_bit2),
      .predicted_addr_bit3(predicted_addr_bit3));
   // Sample mid-cycle, away from the launching edge
   always @(negedge clk) begin
      if (!addr_strobe_n) strobe_cnt++;
      if (addr_strobe_n && !req_ready && !data_ready_n) begin
         a_q.push_back(bus.addr);
         be_q.push_back(bus.byte_enables_n);
         l_q.push_back(last_cycle_n);
         p_q.push_back({predicted_addr_bit3, predicted_addr_bit2});
         c_q.push_back({bus.mem_io, bus.data_code, bus.write_read});
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic run(input logic [31:0] a, input logic [4:0] n,
                      input logic [4:0] f, input logic k);
      int i;
      a_q.delete();
      be_q.delete();
      l_q.delete();
      p_q.delete();
      c_q.delete();
      strobe_cnt = 0;
      @(posedge clk);
      req_valid <= 1'b1;
      req <= {a, n, f};
      cache_enable_in_n <= k;
      for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(negedge clk);
      if (i == 50) begin
         miscompares++;
         results();
      end
      @(posedge clk);
      req_valid <= 1'b0;
      for (i = 0; i < 300 && xfer_done !== 1'b1; i++) @(negedge clk);
      if (i == 300) begin
         miscompares++;
         results();
      end
   endtask
   task automatic chk_seq(input logic [31:4] hi, input logic [1:0] d0,
                          input int n);
      cmp(32'(a_q.size()), 32'(n));
      for (int k = 0; k < n; k++) begin
         cmp(32'(a_q[k]), 32'({hi, d0 ^ 2'(k / 2)}));
         cmp(32'(p_q[k]), 32'(d0 ^ 2'(k / 2)));
         cmp(32'(be_q[k]), k % 2 ? 32'h3 : 32'h0);
         cmp(32'(l_q[k]), 32'(k != n - 1));
      end
   endtask
   task automatic s_pairs();
      logic [3:0] off [4] = '{4'h4, 4'h1, 4'h9, 4'h8};
      logic [4:0] len [4] = '{5'h4, 5'h3, 5'h2, 5'h3};
      logic [3:0] b1 [4] = '{4'h0, 4'h1, 4'h9, 4'h8};
      for (int c = 0; c < 8; c++) begin
         slow <= c[0];
         run(32'h1234_5670 | 32'(off[c % 4]), len[c % 4],
             c < 4 ? 5'h14 : 5'h00, 1'b1);
         cmp(32'(strobe_cnt), 32'h1);
         cmp(32'(be_q.size()), 32'h2);
         cmp(32'(be_q[0]), 32'(b1[c % 4]));
         cmp(32'(be_q[1]), c % 4 < 2 ? 32'h3 : 32'hb);
         cmp(32'({l_q[0], l_q[1]}), 32'h2);
         cmp(32'(a_q[1]), (32'h1234_5670 | 32'(off[c % 4])) >> 2);
         cmp(32'(c_q[1]), c < 4 ? 32'h7 : 32'h2);
      end
   endtask
   task automatic s_line();
      for (int d = 0; d < 4; d++) begin
         slow <= d[0];
         run(32'h0000_a000 | 32'(d * 4), 5'h4, 5'h10, 1'b0);
         chk_seq(28'h0000a00, 2'(d), 8);
         cmp(32'(page_cache_disable), 32'h0);
      end
   endtask
   task automatic s_code();
      slow <= 1'b1;
      run(32'h0000_b008, 5'h2, 5'h1a, 1'b1);
      chk_seq(28'h0000b00, 2'h2, 8);
      cmp(32'(page_cache_disable), 32'h1);
      cmp(32'(c_q[7]), 32'h4);
      slow <= 1'b0;
      run(32'h0000_b008, 5'h8, 5'h12, 1'b1);
      chk_seq(28'h0000b00, 2'h2, 4);
   endtask
   task automatic s_split();
      run(32'h0000_c000, 5'h8, 5'h14, 1'b1);
      cmp(32'(strobe_cnt), 32'h2);
      cmp(32'({l_q[0], l_q[1], l_q[2], l_q[3]}), 32'ha);
      cmp(32'(a_q[2]), 32'h3001);
   endtask
   task automatic s_locked();
      for (int i = 0; i < 2; i++) begin
         run(32'h0000_d000, 5'h4, i ? 5'h10 : 5'h11, i[0]);
         cmp(32'(be_q.size() <= 4), 32'h1);
         cmp(32'(lock_n), 32'(i));
      end
   endtask
   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      s_pairs();
      s_line();
      s_code();
      s_split();
      s_locked();
      results();
   end
endmodule
`default_nettype wire
